// ===== rtl/dfilt_pkg.sv
// Constants and types of the per-channel decimation filter.
// Assumes one clock, the main clock, which also paces the modulator bit strobe.
package dfilt_pkg;
	// ****************************************
	// Widths
	// ****************************************
	localparam int RES_W = 24;
	localparam int ACC_W = 31;
	localparam int FAST_W = 15;
	localparam int POST_W = 28;
	localparam int CNT_W = 14;
	localparam int SET_W = 16;
	localparam int FIFO_DEPTH = 16;
	// ****************************************
	// Ratio decode (log2 of the ratio)
	// ****************************************
	localparam logic [3:0] LOG_RATIO_DOUBLE = 4'h6;
	localparam logic [3:0] LOG_RATIO_BASE = 4'h7;
	localparam logic [3:0] LOG_SINC3_MAX = 4'hA;
	localparam logic [4:0] SINC3_ORDER = 5'h3;
	localparam logic [4:0] NORM_TOP = 5'h1E;
	// ****************************************
	// Settling time, in main clock periods
	// ****************************************
	localparam int SETTLE_SINC3_MULT = 3;
	localparam int SETTLE_FIXED_CLK = 48;
	localparam int SETTLE_R2048_CLK = 6192;
	localparam int SETTLE_R4096_CLK = 10288;
	localparam int SETTLE_R8192_CLK = 18480;
	localparam int SETTLE_R16384_CLK = 34864;
	// ****************************************
	// Output path, Gray coded along start-up
	// ****************************************
	typedef enum logic [1:0] {
		PATH_FAST0 = 2'b00,
		PATH_FAST1 = 2'b01,
		PATH_SINC3 = 2'b11
	} path_t;
endpackage : dfilt_pkg

// ===== rtl/dec_filter.sv
// Decimation filter of one channel: fast sinc1 path, sinc3 path, sinc1 post stage, result FIFO.
// Assumes modulator bits and configuration come from logic on sys_clk; ratio changes only in standby.
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Result FIFO
// ****************************************
module fifo_buf #(
	parameter int W = 24,
	parameter int D = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic rdy_r, rdy_nxt, val_r, val_nxt, push, pop;

	// Pointer and level update; flags are registered so both sides see flop outputs
	always_comb begin
		push = in_valid && rdy_r;
		pop = val_r && out_ready;
		wr_nxt = push ? AW'(wr_r + 1'b1) : wr_r;
		rd_nxt = pop ? AW'(rd_r + 1'b1) : rd_r;
		cnt_nxt = (AW+1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
		rdy_nxt = cnt_nxt != (AW+1)'(D);
		val_nxt = cnt_nxt != '0;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
			rdy_r <= 1'b1;
			val_r <= 1'b0;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
			rdy_r <= rdy_nxt;
			val_r <= val_nxt;
		end
	end

	// Storage has no reset; only words below the level are ever read
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_r] <= in_data;
		end
	end

	assign in_ready = rdy_r;
	assign out_valid = val_r;
	assign out_data = mem[rd_r];
endmodule : fifo_buf

module dec_filter import dfilt_pkg::*; #(
	parameter int SETTLE_R2048 = SETTLE_R2048_CLK,
	parameter int SETTLE_R4096 = SETTLE_R4096_CLK,
	parameter int SETTLE_R8192 = SETTLE_R8192_CLK,
	parameter int SETTLE_R16384 = SETTLE_R16384_CLK
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Configuration
	input wire logic [2:0] decimation_ratio_select,
	input wire logic double_rate,
	input wire logic restart,
	// Modulator bitstream
	input wire logic mod_bit,
	input wire logic mod_valid,
	output logic mod_ready,
	// Conversion results
	output logic [RES_W-1:0] res_data,
	output logic res_valid,
	input wire logic res_ready,
	// Status
	output logic fast_path_active,
	output logic settle_pending
);
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [CNT_W-1:0] mask_of(input logic [3:0] k);
		return CNT_W'((15'h1 << k) - 15'h1);
	endfunction : mask_of
	// Scale a sum with full scale 2^sh to full scale 2^30, keep the top result bits
	function automatic logic [RES_W-1:0] norm(input logic [ACC_W-1:0] v, input logic [4:0] sh);
		logic [ACC_W-1:0] t;
		t = v << (NORM_TOP - sh);
		return t[ACC_W-1:ACC_W-RES_W];
	endfunction : norm
	function automatic logic [SET_W-1:0] settle_len(input logic [3:0] k);
		case (k)
			4'hB: settle_len = SET_W'(SETTLE_R2048);
			4'hC: settle_len = SET_W'(SETTLE_R4096);
			4'hD: settle_len = SET_W'(SETTLE_R8192);
			4'hE: settle_len = SET_W'(SETTLE_R16384);
			default: settle_len = SET_W'(SETTLE_SINC3_MULT * (32'h1 << k) + SETTLE_FIXED_CLK);
		endcase
	endfunction : settle_len

	// ****************************************
	// Filter state
	// ****************************************
	path_t path_r, path_nxt;
	logic [ACC_W-1:0] i1_r, i1_nxt, i2_r, i2_nxt, i3_r, i3_nxt;
	logic [ACC_W-1:0] z1_r, z1_nxt, z2_r, z2_nxt, z3_r, z3_nxt, c1, c2, c3;
	logic [FAST_W-1:0] f_r, f_nxt, f_sum;
	logic [POST_W-1:0] p_r, p_nxt, p_sum;
	logic [CNT_W-1:0] fc_r, fc_nxt, mask, mask3;
	logic [SET_W-1:0] settle_r, settle_nxt;
	logic [3:0] k, k3, mlog;
	logic [RES_W-1:0] s3n, fast_val, sinc_val, conv_val;
	logic accept, s3_tick, conv_tick, fast_r, fast_nxt, pend_r, pend_nxt;
	logic f_in_ready, f_out_valid, f_pop;
	logic [RES_W-1:0] f_out_data;
	// Ratio decode, both paths and path selection
	always_comb begin
		k = double_rate ? LOG_RATIO_DOUBLE : 4'(LOG_RATIO_BASE + {1'b0, decimation_ratio_select});
		k3 = (k > LOG_SINC3_MAX) ? LOG_SINC3_MAX : k;
		mlog = 4'(k - k3);
		mask = mask_of(k);
		mask3 = mask_of(k3);
		accept = mod_valid && f_in_ready;
		s3_tick = accept && ((fc_r & mask3) == mask3);
		conv_tick = accept && (fc_r == mask);
		// Three differencers on the decimated third integrator
		c1 = ACC_W'(i3_r - z1_r);
		c2 = ACC_W'(c1 - z2_r);
		c3 = ACC_W'(c2 - z3_r);
		s3n = norm(c3, 5'(SINC3_ORDER * {1'b0, k3}));
		f_sum = FAST_W'(f_r + {{(FAST_W-1){1'b0}}, mod_bit});
		fast_val = norm(ACC_W'(f_sum), {1'b0, k});
		p_sum = POST_W'(p_r + {{(POST_W-RES_W){1'b0}}, s3n});
		sinc_val = (mlog == 4'h0) ? s3n : RES_W'(p_sum >> mlog);
		conv_val = (path_r == PATH_SINC3) ? sinc_val : fast_val;
		{i1_nxt, i2_nxt, i3_nxt} = {i1_r, i2_r, i3_r};
		{z1_nxt, z2_nxt, z3_nxt} = {z1_r, z2_r, z3_r};
		{f_nxt, p_nxt, fc_nxt} = {f_r, p_r, fc_r};
		path_nxt = path_r;
		// Both paths integrate every bit, whichever one is selected
		if (accept) begin
			i1_nxt = ACC_W'(i1_r + {{(ACC_W-1){1'b0}}, mod_bit});
			i2_nxt = ACC_W'(i2_r + i1_r);
			i3_nxt = ACC_W'(i3_r + i2_r);
			f_nxt = conv_tick ? '0 : f_sum;
			fc_nxt = conv_tick ? '0 : CNT_W'(fc_r + 1'b1);
		end
		if (s3_tick) begin
			z1_nxt = i3_r;
			z2_nxt = c1;
			z3_nxt = c2;
			p_nxt = conv_tick ? '0 : p_sum;
		end
		if (conv_tick) begin
			case (path_r)
				PATH_FAST0: path_nxt = PATH_FAST1;
				PATH_FAST1: path_nxt = PATH_SINC3;
				default: path_nxt = PATH_SINC3;
			endcase
		end
		// Restart clears the filter history but not the start-up path choice
		if (restart) begin
			{i1_nxt, i2_nxt, i3_nxt, z1_nxt, z2_nxt, z3_nxt} = '0;
			{f_nxt, p_nxt, fc_nxt} = '0;
		end
		fast_nxt = path_nxt != PATH_SINC3;
		// Settling is reported as a status only; results are never held back
		if (restart) begin
			settle_nxt = settle_len(k);
		end else if (settle_r != '0) begin
			settle_nxt = SET_W'(settle_r - 1'b1);
		end else begin
			settle_nxt = settle_r;
		end
		pend_nxt = settle_nxt != '0;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			path_r <= PATH_FAST0;
			{i1_r, i2_r, i3_r, z1_r, z2_r, z3_r} <= '0;
			{f_r, p_r, fc_r} <= '0;
			fast_r <= 1'b1;
			settle_r <= '0;
			pend_r <= 1'b0;
		end else begin
			path_r <= path_nxt;
			{i1_r, i2_r, i3_r, z1_r, z2_r, z3_r} <= {i1_nxt, i2_nxt, i3_nxt, z1_nxt, z2_nxt, z3_nxt};
			{f_r, p_r, fc_r} <= {f_nxt, p_nxt, fc_nxt};
			fast_r <= fast_nxt;
			settle_r <= settle_nxt;
			pend_r <= pend_nxt;
		end
	end

	// ****************************************
	// Result buffer and output register
	// ****************************************
	// Full FIFO stalls the modulator strobe, so no result is dropped
	fifo_buf #(.W(RES_W), .D(FIFO_DEPTH)) u_fifo (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.in_valid(conv_tick),
		.in_ready(f_in_ready),
		.in_data(conv_val),
		.out_valid(f_out_valid),
		.out_ready(f_pop),
		.out_data(f_out_data)
	);
	logic res_valid_r, res_valid_nxt;
	logic [RES_W-1:0] res_data_r, res_data_nxt;

	// One output stage so the result port is a flop
	always_comb begin
		f_pop = f_out_valid && (!res_valid_r || res_ready);
		res_valid_nxt = f_pop || (res_valid_r && !res_ready);
		res_data_nxt = f_pop ? f_out_data : res_data_r;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			res_valid_r <= 1'b0;
			res_data_r <= '0;
		end else begin
			res_valid_r <= res_valid_nxt;
			res_data_r <= res_data_nxt;
		end
	end

	assign res_valid = res_valid_r;
	assign res_data = res_data_r;
	assign mod_ready = f_in_ready;
	assign fast_path_active = fast_r;
	assign settle_pending = pend_r;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	fast_result_a: assert property (conv_tick && path_r != PATH_SINC3 |-> conv_val == fast_val)
		else $error("fast path not selected at start-up");
	stay_sinc3_a: assert property (path_r == PATH_SINC3 |=> path_r == PATH_SINC3)
		else $error("left third-order path");
	switch_sinc3_a: assert property (conv_tick && path_r == PATH_FAST1 |=> path_r == PATH_SINC3 && !fast_r)
		else $error("no switch after second conversion");
	direct_sinc3_a: assert property (conv_tick && path_r == PATH_SINC3 && k <= LOG_SINC3_MAX |-> conv_val == s3n)
		else $error("post stage used at low ratio");
	post_align_a: assert property (conv_tick |-> s3_tick)
		else $error("conversion not on third-order boundary");
	restart_clear_a: assert property (restart |=> fc_r == '0 && i3_r == '0 && f_r == '0)
		else $error("restart did not clear filter");
	settle_load_a: assert property (restart |=> settle_r == $past(settle_len(k)))
		else $error("wrong settling length");
	settle_count_a: assert property (settle_r > 1 && !restart |=> settle_r == $past(settle_r) - 1 && pend_r)
		else $error("settling count does not step");
	parallel_feed_a: assert property (accept && !restart && path_r != PATH_SINC3 |=> i1_r == $past(i1_r) + $past(mod_bit))
		else $error("third-order path idle during fast path");

	reach_sinc3_c: cover property (conv_tick && path_r == PATH_FAST1 ##1 path_r == PATH_SINC3);
	post_stage_c: cover property (conv_tick && mlog != 4'h0 && path_r == PATH_SINC3);
	fifo_full_c: cover property (mod_valid && !f_in_ready);
	restart_c: cover property (restart ##1 pend_r);
endmodule : dec_filter

`default_nettype wire

// ===== tb/host_model.sv
// Host-side model: takes conversion results with random stalls.
// Assumes results arrive on sys_clk; hold stops all acceptance.
`timescale 1ns/1ns
`default_nettype none
module host_model (
	// Clock
	input wire logic sys_clk,
	// Result handshake
	input wire logic hold,
	output var logic res_ready,
	// Settling status
	input wire logic settle_pending,
	output logic usable
);
	// Ready moves on the falling edge so the taking edge never races it
	initial res_ready = 1'b0;
	always @(negedge sys_clk) begin
		res_ready <= !hold && ($urandom % 3 != 0);
	end
	// Results taken while settling are marked untrusted by a low usable
	assign usable = !settle_pending;
endmodule : host_model
`default_nettype wire

// ===== tb/decimation_filter_path_select_bench.sv
// Self-checking bench of the decimation filter with a host model.
// Assumes a 100 MHz sys_clk; the 2048 settling count is cut to 300.
`timescale 1ns/1ns
`default_nettype none
module decimation_filter_path_select_bench import dfilt_pkg::*;;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [2:0] sel = 3'h0;
	logic dbl = 1'b0;
	logic restart = 1'b0;
	logic mod_bit = 1'b0;
	logic mod_valid = 1'b0;
	logic hold = 1'b0;
	logic took = 1'b0;
	logic mod_ready, res_valid, res_ready, fast_path_active, settle_pending;
	logic [RES_W-1:0] res_data;
	logic [RES_W-1:0] exp_q[$];
	int bad_count = 0;
	int checked = 0;
	int tk;
	int rat;
	int runs = 0;
	// Clock and bit acceptance record
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) took <= mod_valid && mod_ready;
	dec_filter #(.SETTLE_R2048(300)) DUT (
		.sys_clk(sys_clk), .nrst(nrst), .decimation_ratio_select(sel),
		.double_rate(dbl), .restart(restart), .mod_bit(mod_bit),
		.mod_valid(mod_valid), .mod_ready(mod_ready), .res_data(res_data),
		.res_valid(res_valid), .res_ready(res_ready),
		.fast_path_active(fast_path_active), .settle_pending(settle_pending)
	);
	host_model host (
		.sys_clk(sys_clk), .hold(hold), .res_ready(res_ready),
		.settle_pending(settle_pending), .usable()
	);
	// ****************************************
	// Checking
	// ****************************************
	task chk(input logic [RES_W-1:0] s, input logic [RES_W-1:0] e);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task chkf(input logic s, input logic e);
		chk({23'h0, s}, {23'h0, e});
	endtask : chkf
	// First third-order result after reset misses its last tap: full scale less one part in N cubed up to N = 1024, full scale above
	function automatic logic [RES_W-1:0] third_exp(input int r);
		longint n3;
		n3 = longint'(r) * r * r;
		if (r > 1024) begin
			return 24'h800000;
		end
		return RES_W'((64'h40000000 - 64'h40000000 / n3) >> 7);
	endfunction : third_exp
	// Oldest note against each result the host takes
	always @(posedge sys_clk) begin
		if (nrst && res_valid === 1'b1 && res_ready) begin
			if (exp_q.size() == 0) begin
				chk(res_data, ~res_data);
			end else begin
				chk(res_data, exp_q.pop_front());
			end
		end
	end
	task results;
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results
	// ****************************************
	// Stimulus
	// ****************************************
	task reset_dut;
		nrst = 1'b0;
		runs = 0;
		repeat (2) @(negedge sys_clk);
		chkf(mod_ready, 1'b1);
		chkf(res_valid, 1'b0);
		chkf(fast_path_active, 1'b1);
		chkf(settle_pending, 1'b0);
		nrst = 1'b1;
	endtask : reset_dut
	// Bits with random gaps; a note per completed run of rat bits
	task send(input int n, input logic b, input logic [RES_W-1:0] e, input int lim);
		tk = 0;
		while (tk < n && lim > 0) begin
			@(negedge sys_clk);
			lim--;
			if (took) begin
				tk++;
				if (tk % rat == 0) begin
					runs++;
					exp_q.push_back((b && runs == 3) ? third_exp(rat) : e);
				end
			end
			mod_bit = b;
			mod_valid = (tk < n && lim > 0) && ($urandom % 4 != 0);
		end
	endtask : send
	task settle(input int s);
		@(negedge sys_clk);
		restart = 1'b1;
		@(negedge sys_clk);
		restart = 1'b0;
		repeat (s - 4) @(negedge sys_clk);
		chkf(settle_pending, 1'b1);
		repeat (8) @(negedge sys_clk);
		chkf(settle_pending, 1'b0);
	endtask : settle
	task drain;
		int w;
		w = 0;
		while (exp_q.size() != 0 && w < 20000) begin
			@(negedge sys_clk);
			w++;
		end
		chk(RES_W'(exp_q.size()), 24'h0);
	endtask : drain
	// Main sequence: ratios 64 to 2048, restart with zeros, then a full buffer
	initial begin
		int i;
		void'($urandom(32'hCCEA));
		for (i = 0; i < 6; i++) begin
			// Ratio moves only while reset holds the converter idle
			dbl = (i == 0);
			sel = 3'(i == 0 ? 0 : i - 1);
			rat = 64 << i;
			reset_dut();
			settle(i == 5 ? 300 : 3 * rat + 48);
			send(rat, 1'b1, 24'h800000, 100000);
			repeat (2) @(negedge sys_clk);
			chkf(fast_path_active, 1'b1);
			send(rat, 1'b1, 24'h800000, 100000);
			repeat (2) @(negedge sys_clk);
			chkf(fast_path_active, 1'b0);
			send(rat, 1'b1, 24'h800000, 100000);
			drain();
			$display("ratio %0d done", rat);
		end
		// Restart must clear the filter history (not the path choice), so zeros give zero at once
		settle(300);
		send(3 * rat, 1'b0, 24'h0, 100000);
		drain();
		chkf(fast_path_active, 1'b0);
		$display("restart done");
		dbl = 1'b1;
		sel = 3'h0;
		rat = 64;
		reset_dut();
		hold = 1'b1;
		send(20 * 64, 1'b1, 24'h800000, 2000);
		chkf(mod_ready, 1'b0);
		chk(RES_W'(tk), RES_W'((FIFO_DEPTH + 1) * 64));
		hold = 1'b0;
		drain();
		$display("fill done");
		results();
	end
	// Watchdog well beyond the expected run length
	initial begin
		#900000;
		bad_count++;
		results();
	end
endmodule : decimation_filter_path_select_bench
`default_nettype wire
